// File: hdl/cii_issuer.sv
// Issuer end: queues instructions, drives them one at a time, queues results.
// Assumes the slave end on the same CLK through cii_if.
`timescale 1ns/1ps
`default_nettype none
module cii_issuer
    import cii_pkg::*;
#(
    parameter int  OPERANDS   = OPERANDS_DEF,
    parameter int  FIXED_LEN  = FIXED_LEN_DEF,
    parameter bit  MULTICYCLE = 1'b0,
    parameter bit  USE_START  = 1'b1,
    parameter bit  USE_DONE   = 1'b1,
    parameter bit  USE_EXT    = 1'b0,
    parameter bit  USE_REG_A  = 1'b0,
    parameter bit  USE_REG_B  = 1'b0,
    parameter bit  USE_REG_C  = 1'b0
) (
    input  wire logic              CLK,
    input  wire logic              SRST,
    cii_if.issuer                  LINK,
    input  wire logic [INSTR_W-1:0] INSTR_DATA,
    input  wire logic              INSTR_VALID,
    output logic                   INSTR_READY,
    output logic [DATA_W-1:0]      RES_DATA,
    output logic                   RES_VALID,
    input  wire logic              RES_READY,
    input  wire logic              GATE_REQ,
    input  wire logic [TMO_W-1:0]  GATE_TMO,
    input  wire logic [TMO_W-1:0]  INSTR_TMO,
    input  wire logic [TMO_W-1:0]  RES_TMO,
    input  wire logic [LVL_W-1:0]  IQ_MAX,
    input  wire logic [LVL_W-1:0]  IQ_MIN,
    input  wire logic [LVL_W-1:0]  RQ_MAX,
    input  wire logic [LVL_W-1:0]  RQ_MIN,
    output logic                   EV_ISSUE,
    output logic                   EV_RESULT,
    output logic                   EV_DONE_ALL,
    output logic                   EV_IQ_MAX,
    output logic                   EV_IQ_MIN,
    output logic                   EV_RQ_MAX,
    output logic                   EV_RQ_MIN,
    output logic                   ERR_UNEXP,
    output logic                   ERR_GATE_TMO,
    output logic                   ERR_INSTR_TMO,
    output logic                   ERR_RES_TMO
);
    typedef enum logic [1:0] {
        CII_IDLE = 2'b00,
        CII_BUSY = 2'b01
    } cii_state_t;

    cii_state_t          state;
    cii_instr_t          cur;
    cii_instr_t          q_head;
    logic                q_valid;
    logic                q_take;
    logic [LVL_W-1:0]    iq_lvl;
    logic [LVL_W-1:0]    rq_lvl;
    logic                rq_ready;
    logic                cap;
    logic [TMO_W-1:0]    cyc;
    logic [TMO_W-1:0]    gate_cnt;
    logic                first;
    logic                stall_out;

    // Instruction queue
    cii_fifo #(.WIDTH(INSTR_W), .DEPTH(FIFO_DEPTH), .CW(LVL_W)) u_iq (
        .CLK       (CLK),
        .SRST      (SRST),
        .in_data   (INSTR_DATA),
        .in_valid  (INSTR_VALID),
        .in_ready  (INSTR_READY),
        .out_data  (q_head),
        .out_valid (q_valid),
        .out_ready (q_take),
        .level     (iq_lvl)
    );

    // Result queue; full result queue stalls issue, so back-pressure reaches the source
    cii_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(LVL_W)) u_rq (
        .CLK       (CLK),
        .SRST      (SRST),
        .in_data   (LINK.result),
        .in_valid  (cap),
        .in_ready  (rq_ready),
        .out_data  (RES_DATA),
        .out_valid (RES_VALID),
        .out_ready (RES_READY),
        .level     (rq_lvl)
    );

    // Take next only when idle and room for its result
    assign q_take = (state == CII_IDLE) && q_valid && rq_ready && LINK.clk_en;

    // Capture point by mode; fault injection can sample one cycle early
    always_comb begin
        cap = 1'b0;
        if (state == CII_BUSY) begin
            if (!MULTICYCLE) begin
                cap = !first;
            end else if (USE_DONE) begin
                cap = LINK.done;
            end else if (cur.err == ERR_EARLY) begin
                cap = (cyc == TMO_W'(FIXED_LEN - 2));
            end else begin
                cap = (cyc == TMO_W'(FIXED_LEN - 1));
            end
        end
    end

    // Sequencer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= CII_IDLE;
            cur   <= '0;
            cyc   <= '0;
            first <= 1'b0;
        end else begin
            first <= q_take;
            unique case (state)
                CII_IDLE: begin
                    if (q_take) begin
                        cur   <= q_head;
                        cyc   <= '0;
                        state <= CII_BUSY;
                    end
                end
                CII_BUSY: begin
                    cyc <= cyc + 1'b1;
                    if (cap || (INSTR_TMO != TMO_OFF && cyc >= INSTR_TMO)) begin
                        state <= CII_IDLE;
                    end
                end
                default: state <= CII_IDLE;
            endcase
        end
    end

    // A corrupt hold fault flips the dataa bits after the first cycle; datab holds
    assign stall_out = (cur.err == ERR_NOHOLD) && !first;

    // Bus drive; idle drives X except the three selects (high) and start (low)
    always_ff @(posedge CLK) begin
        if (SRST || state != CII_BUSY || cap) begin
            LINK.dataa <= 'x;
            LINK.datab <= 'x;
            LINK.n_ext <= 'x;
            LINK.ra    <= 'x;
            LINK.rb    <= 'x;
            LINK.rc    <= 'x;
            LINK.rd_a  <= 1'b1;
            LINK.rd_b  <= 1'b1;
            LINK.wr_c  <= 1'b1;
            LINK.start <= 1'b0;
        end else begin
            LINK.dataa <= (OPERANDS >= 1) ? cur.opa ^ {DATA_W{stall_out}} : 'x;
            LINK.datab <= (OPERANDS == 2) ? cur.opb : 'x;
            LINK.n_ext <= USE_EXT ? cur.ext : 'x;
            LINK.ra    <= USE_REG_A ? cur.ra : 'x;
            LINK.rb    <= USE_REG_B ? cur.rb : 'x;
            LINK.rc    <= USE_REG_C ? cur.rc : 'x;
            LINK.rd_a  <= USE_REG_A ? cur.rd_a : 1'b1;
            LINK.rd_b  <= USE_REG_B ? cur.rd_b : 1'b1;
            LINK.wr_c  <= USE_REG_C ? cur.wr_c : 1'b1;
            LINK.start <= USE_START && first && cur.err != ERR_NOSTART;
        end
    end

    // Clock gate follows request at the edge; timeout counts gated time
    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.clk_en  <= 1'b1;
            gate_cnt     <= '0;
            ERR_GATE_TMO <= 1'b0;
        end else begin
            LINK.clk_en  <= GATE_REQ;
            gate_cnt     <= LINK.clk_en ? '0 : gate_cnt + 1'b1;
            ERR_GATE_TMO <= (GATE_TMO != TMO_OFF) && !LINK.clk_en
                            && (gate_cnt == GATE_TMO);
        end
    end

    // Event and error flags; the queue threshold flags are levels held while past their limit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            EV_ISSUE      <= 1'b0;
            EV_RESULT     <= 1'b0;
            EV_DONE_ALL   <= 1'b0;
            EV_IQ_MAX     <= 1'b0;
            EV_IQ_MIN     <= 1'b0;
            EV_RQ_MAX     <= 1'b0;
            EV_RQ_MIN     <= 1'b0;
            ERR_UNEXP     <= 1'b0;
            ERR_INSTR_TMO <= 1'b0;
            ERR_RES_TMO   <= 1'b0;
        end else begin
            EV_ISSUE      <= q_take;
            EV_RESULT     <= cap;
            EV_DONE_ALL   <= cap && !q_valid;
            EV_IQ_MAX     <= iq_lvl > IQ_MAX;
            EV_RQ_MAX     <= rq_lvl > RQ_MAX;
            EV_IQ_MIN     <= iq_lvl < IQ_MIN;
            EV_RQ_MIN     <= rq_lvl < RQ_MIN;
            ERR_UNEXP     <= MULTICYCLE && USE_DONE && LINK.done
                             && state != CII_BUSY;
            ERR_INSTR_TMO <= state == CII_BUSY && INSTR_TMO != TMO_OFF
                             && cyc == INSTR_TMO;
            ERR_RES_TMO   <= state == CII_BUSY && !cap && RES_TMO != TMO_OFF
                             && cyc == RES_TMO;
        end
    end
endmodule : cii_issuer
`default_nettype wire

// File: hdl/cii_pkg.sv
// Package for the custom instruction issuer and its slave end.
// Assumes one interface clock shared by both ends.
package cii_pkg;
    localparam int DATA_W      = 32;
    localparam int EXT_W       = 1;
    localparam int ADDR_W      = 5;
    localparam int FIFO_DEPTH  = 8;
    localparam int LVL_W       = 4;
    localparam int TMO_W       = 16;
    localparam int ERR_W       = 2;
    localparam int OPERANDS_DEF   = 2;
    localparam int FIXED_LEN_DEF  = 2;
    localparam logic [TMO_W-1:0] TMO_OFF = 16'h0000;
    // Error injection codes
    localparam logic [ERR_W-1:0] ERR_NONE    = 2'h0;
    localparam logic [ERR_W-1:0] ERR_NOSTART = 2'h1;
    localparam logic [ERR_W-1:0] ERR_EARLY   = 2'h2;
    localparam logic [ERR_W-1:0] ERR_NOHOLD  = 2'h3;
    // Instruction entry: err, idle-free fields
    typedef struct packed {
        logic [ERR_W-1:0]  err;
        logic [DATA_W-1:0] opa;
        logic [DATA_W-1:0] opb;
        logic [EXT_W-1:0]  ext;
        logic [ADDR_W-1:0] ra;
        logic [ADDR_W-1:0] rb;
        logic [ADDR_W-1:0] rc;
        logic              rd_a;
        logic              rd_b;
        logic              wr_c;
    } cii_instr_t;
    localparam int INSTR_W = $bits(cii_instr_t);
endpackage : cii_pkg

// File: hdl/cii_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cii_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH+1)
) (
    input  wire logic             CLK,
    input  wire logic             SRST,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [CW-1:0]    level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic             push;
    logic             pop;
    logic [CW-1:0]    next_level;

    // Flags are registered from the next level so both handshakes leave flip-flops
    assign out_data   = mem[rp];
    assign push       = in_valid && in_ready;
    assign pop        = out_valid && out_ready;
    assign next_level = level + CW'(push) - CW'(pop);

    // Storage
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge CLK) begin
        if (SRST) begin
            wp        <= '0;
            rp        <= '0;
            level     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            if (pop)  rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            level     <= next_level;
            in_ready  <= (next_level != CW'(DEPTH));
            out_valid <= (next_level != '0);
        end
    end
endmodule : cii_fifo
`default_nettype wire

// File: hdl/cii_if.sv
// Custom instruction link between the issuer and the slave logic.
// Assumes both ends share CLK; no clocking blocks.
`timescale 1ns/1ps
`default_nettype none
interface cii_if;
    import cii_pkg::*;
    logic              clk_en;
    logic              start;
    logic              done;
    logic [DATA_W-1:0] dataa;
    logic [DATA_W-1:0] datab;
    logic [EXT_W-1:0]  n_ext;
    logic [ADDR_W-1:0] ra;
    logic [ADDR_W-1:0] rb;
    logic [ADDR_W-1:0] rc;
    logic              rd_a;
    logic              rd_b;
    logic              wr_c;
    logic [DATA_W-1:0] result;
    modport issuer (output clk_en, start, dataa, datab, n_ext, ra, rb, rc, rd_a, rd_b,
                    wr_c, input done, result);
    modport slave  (input clk_en, start, dataa, datab, n_ext, ra, rb, rc, rd_a, rd_b,
                    wr_c, output done, result);
endinterface : cii_if
`default_nettype wire

// File: hdl/cii_slave.sv
// Slave end: executes instructions from cii_if and returns a result.
// Assumes the issuer on the same CLK; the user side computes the result.
`timescale 1ns/1ps
`default_nettype none
module cii_slave
    import cii_pkg::*;
#(
    parameter int FIXED_LEN = FIXED_LEN_DEF,
    parameter bit USE_DONE  = 1'b1
) (
    input  wire logic              CLK,
    input  wire logic              SRST,
    cii_if.slave                   LINK,
    output logic [DATA_W-1:0]      OP_A,
    output logic [DATA_W-1:0]      OP_B,
    output logic [EXT_W-1:0]       OP_EXT,
    output logic                   OP_START,
    input  wire logic [DATA_W-1:0] USER_RESULT,
    input  wire logic              USER_DONE
);
    // Present operands; start associates result with this instruction
    always_ff @(posedge CLK) begin
        if (SRST) begin
            OP_A     <= '0;
            OP_B     <= '0;
            OP_EXT   <= '0;
            OP_START <= 1'b0;
        end else begin
            OP_A     <= LINK.dataa;
            OP_B     <= LINK.datab;
            OP_EXT   <= LINK.n_ext;
            OP_START <= LINK.start;
        end
    end

    // Result every cycle; without a done port the issuer counts the fixed length
    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.result <= '0;
            LINK.done   <= 1'b0;
        end else begin
            LINK.result <= USER_RESULT;
            LINK.done   <= USE_DONE ? USER_DONE : 1'b0;
        end
    end
endmodule : cii_slave
`default_nettype wire

// File: tb/cii_chk.sv
// Link checker for the custom instruction issuer and slave ends.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module cii_chk
    import cii_pkg::*;
(
    input wire logic              CLK,
    input wire logic              SRST,
    input wire logic              clk_en,
    input wire logic              start,
    input wire logic              done,
    input wire logic [DATA_W-1:0] dataa,
    input wire logic [DATA_W-1:0] datab,
    input wire logic [EXT_W-1:0]  n_ext,
    input wire logic [ADDR_W-1:0] ra,
    input wire logic [ADDR_W-1:0] rb,
    input wire logic [ADDR_W-1:0] rc,
    input wire logic              rd_a,
    input wire logic              rd_b,
    input wire logic              wr_c
);
    logic busy;
    // Open from start to done; an aborted instruction would leave it set
    always_ff @(posedge CLK) begin
        if (SRST) busy <= 1'b0;
        else if (start) busy <= 1'b1;
        else if (done) busy <= 1'b0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_start_single: assert property (start |=> !start)
        else $error("start longer than one cycle");
    a_start_idle: assert property (start |-> !busy)
        else $error("start while busy");
    a_done_no_start: assert property (done |-> !start)
        else $error("start with done");
    a_gate_issue: assert property (start |-> $past(clk_en))
        else $error("issue while gated");
    a_hold_ops: assert property ((start || busy) && !done |=>
        $stable(dataa) && $stable(datab) && $stable(n_ext))
        else $error("operands moved");
    a_hold_regs: assert property ((start || busy) && !done |=>
        $stable({ra, rb, rc, rd_a, rd_b, wr_c}))
        else $error("register fields moved");
    a_sel_idle: assert property (!busy && !start |-> rd_a && rd_b && wr_c)
        else $error("idle selects not high");
    a_busy_quiet: assert property (busy && !done |-> !start)
        else $error("second start before done");
endmodule : cii_chk
`default_nettype wire

// File: tb/custom_instruction_issuer_tb.sv
// Bench for the issuer and slave ends joined by cii_if.
// Assumes the hdl files compile first; the slave user side is local logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %0h vs %0h", $time, (a), (b)); end end
module custom_instruction_issuer_tb;
    import cii_pkg::*;
    logic              CLK = 1'b0;
    logic              SRST, INSTR_VALID, RES_READY, GATE_REQ, RES_VALID, INSTR_READY;
    cii_instr_t        INSTR_DATA;
    logic [TMO_W-1:0]  GATE_TMO, INSTR_TMO, RES_TMO;
    logic [LVL_W-1:0]  IQ_MIN, RQ_MIN;
    logic [DATA_W-1:0] RES_DATA, OP_A, OP_B, USER_RESULT;
    logic              EV_ISSUE, EV_RESULT, EV_DONE_ALL, EV_IQ_MAX, EV_IQ_MIN, EV_RQ_MAX;
    logic              EV_RQ_MIN, ERR_UNEXP, ERR_GATE_TMO, ERR_INSTR_TMO, ERR_RES_TMO;
    logic              OP_START, USER_DONE, spur;
    logic [1:0]        dcnt;
    int                error_cnt, total_checks, n_iss, n_res, n_all, n_gtmo;
    int                n_itmo, n_rtmo, n_unexp;
    always #2.5 CLK = ~CLK;
    // Event pulses are counted so tasks can judge them after the fact
    always @(posedge CLK) begin
        n_iss += (EV_ISSUE === 1'b1);
        n_res += (EV_RESULT === 1'b1);
        n_all += (EV_DONE_ALL === 1'b1);
        n_gtmo += (ERR_GATE_TMO === 1'b1);
        n_itmo += (ERR_INSTR_TMO === 1'b1);
        n_rtmo += (ERR_RES_TMO === 1'b1);
        n_unexp += (ERR_UNEXP === 1'b1);
    end
    // User side answers three cycles after each start
    always @(posedge CLK) begin
        if (SRST === 1'b1) dcnt <= 2'h0;
        else if (OP_START === 1'b1) dcnt <= 2'h3;
        else if (dcnt != 2'h0) dcnt <= dcnt - 2'h1;
    end
    // A stray done can be forced while nothing is outstanding
    assign USER_DONE   = (dcnt == 2'h1) || spur;
    assign USER_RESULT = OP_A ^ OP_B;
    cii_if cii_if_i ();
    cii_issuer #(.MULTICYCLE(1'b1), .USE_EXT(1'b1), .USE_REG_A(1'b1), .USE_REG_B(1'b1),
        .USE_REG_C(1'b1)) cii_issuer_i (.CLK, .SRST, .LINK(cii_if_i), .INSTR_DATA,
        .INSTR_VALID, .INSTR_READY, .RES_DATA, .RES_VALID, .RES_READY, .GATE_REQ, .GATE_TMO,
        .INSTR_TMO, .RES_TMO, .IQ_MAX(4'h4), .IQ_MIN, .RQ_MAX(4'h4),
        .RQ_MIN, .EV_ISSUE, .EV_RESULT, .EV_DONE_ALL, .EV_IQ_MAX, .EV_IQ_MIN,
        .EV_RQ_MAX, .EV_RQ_MIN, .ERR_UNEXP, .ERR_GATE_TMO, .ERR_INSTR_TMO, .ERR_RES_TMO);
    cii_slave cii_slave_i (.CLK, .SRST, .LINK(cii_if_i), .OP_A, .OP_B, .OP_EXT(), .OP_START,
        .USER_RESULT, .USER_DONE);
    cii_chk cii_chk_i (.CLK, .SRST, .clk_en(cii_if_i.clk_en), .start(cii_if_i.start),
        .done(cii_if_i.done), .dataa(cii_if_i.dataa), .datab(cii_if_i.datab),
        .n_ext(cii_if_i.n_ext), .ra(cii_if_i.ra), .rb(cii_if_i.rb), .rc(cii_if_i.rc),
        .rd_a(cii_if_i.rd_a), .rd_b(cii_if_i.rd_b), .wr_c(cii_if_i.wr_c));
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Inputs move 1 ns after the edge so every sample is settled
    task automatic tick;
        @(posedge CLK);
        #1;
    endtask : tick
    task automatic fail_if(input int n);
        if (n > 200) begin
            error_cnt++;
            summarize();
        end
    endtask : fail_if
    // rd_a and rd_b are low in every entry mk builds and wr_c follows i[1], so the idle-high level is visible
    function automatic cii_instr_t mk(input logic [7:0] i);
        mk = '0;
        mk.err = ERR_NONE;
        mk.opa = {24'ha5c300, i};
        mk.opb = {24'h3c0f00, ~i};
        mk.ext = i[0];
        mk.ra = i[4:0];
        mk.rb = ~i[4:0];
        mk.rc = i[4:0] + 5'h3;
        mk.wr_c = i[1];
    endfunction : mk
    task automatic push(input cii_instr_t e);
        int n;
        tick();
        INSTR_DATA = e;
        INSTR_VALID = 1'b1;
        for (n = 0; INSTR_READY !== 1'b1; n++) begin
            fail_if(n);
            tick();
        end
        tick();
        INSTR_VALID = 1'b0;
    endtask : push
    task automatic pop(input cii_instr_t e);
        int n;
        tick();
        for (n = 0; RES_VALID !== 1'b1; n++) begin
            fail_if(n);
            tick();
        end
        `CHK(RES_DATA, e.opa ^ e.opb)
        RES_READY = 1'b1;
        tick();
        RES_READY = 1'b0;
    endtask : pop
    task automatic t_idle;
        `CHK({cii_if_i.rd_a, cii_if_i.rd_b, cii_if_i.wr_c, cii_if_i.start}, 4'he)
        tick();
        tick();
        `CHK(EV_IQ_MIN, 1'b0)
        IQ_MIN = 4'h2;
        tick();
        tick();
        `CHK(EV_IQ_MIN, 1'b1)
        $display("t_idle finished");
    endtask : t_idle
    task automatic t_single;
        cii_instr_t e;
        int         n, i0, a0;
        e = mk(8'h11);
        i0 = n_iss;
        a0 = n_all;
        push(e);
        for (n = 0; cii_if_i.start !== 1'b1; n++) begin
            fail_if(n);
            tick();
        end
        `CHK({cii_if_i.dataa, cii_if_i.datab}, {e.opa, e.opb})
        `CHK({cii_if_i.n_ext, cii_if_i.ra, cii_if_i.rb, cii_if_i.rc}, {e.ext, e.ra, e.rb, e.rc})
        `CHK({cii_if_i.rd_a, cii_if_i.rd_b, cii_if_i.wr_c}, {e.rd_a, e.rd_b, e.wr_c})
        pop(e);
        tick();
        tick();
        `CHK(n_iss - i0, 1)
        `CHK(n_all > a0, 1'b1)
        $display("t_single finished");
    endtask : t_single
    task automatic t_burst;
        cii_instr_t q [8];
        int         i, n, i0, r0;
        // Timeout armed before gating, so it expires only after the queue is full
        GATE_TMO = 16'h0020;
        GATE_REQ = 1'b0;
        i0 = n_iss;
        r0 = n_res;
        for (i = 0; i < 8; i++) begin
            q[i] = mk({5'h08, i[2:0]});
            push(q[i]);
        end
        tick();
        tick();
        `CHK(INSTR_READY, 1'b0)
        `CHK(EV_IQ_MAX, 1'b1)
        `CHK(n_iss - i0, 0)
        `CHK(n_gtmo, 0)
        for (n = 0; n_gtmo == 0; n++) begin
            fail_if(n);
            tick();
        end
        GATE_TMO = TMO_OFF;
        GATE_REQ = 1'b1;
        for (n = 0; n_res < r0 + 8; n++) begin
            fail_if(n);
            tick();
        end
        tick();
        tick();
        `CHK(EV_RQ_MAX, 1'b1)
        for (i = 0; i < 8; i++) pop(q[i]);
        tick();
        tick();
        `CHK({EV_RQ_MIN, EV_IQ_MIN}, 2'h3)
        `CHK(n_iss - i0, 8)
        `CHK(n_res - r0, 8)
        $display("t_burst finished");
    endtask : t_burst
    // Start is suppressed, so no done comes and only INSTR_TMO ends the instruction; RES_TMO only flags
    task automatic t_fault;
        cii_instr_t e;
        int         n, r0, t0, i0, u0;
        e = mk(8'h2c);
        e.err = ERR_NOSTART;
        e.rd_a = 1'b1;
        e.rd_b = 1'b1;
        e.wr_c = 1'b1;
        r0 = n_res;
        t0 = n_rtmo;
        i0 = n_itmo;
        u0 = n_unexp;
        INSTR_TMO = 16'h0006;
        RES_TMO = 16'h0003;
        push(e);
        for (n = 0; n_itmo == i0; n++) begin
            fail_if(n);
            tick();
        end
        INSTR_TMO = TMO_OFF;
        RES_TMO = TMO_OFF;
        tick();
        `CHK(n_itmo - i0, 1)
        `CHK(n_rtmo - t0, 1)
        `CHK(n_res - r0, 0)
        spur = 1'b1;
        tick();
        spur = 1'b0;
        for (n = 0; n < 4; n++) tick();
        `CHK(n_unexp - u0, 1)
        $display("t_fault finished");
    endtask : t_fault
    initial begin
        SRST = 1'b1;
        INSTR_VALID = 1'b0;
        INSTR_DATA = '0;
        RES_READY = 1'b0;
        GATE_REQ = 1'b1;
        GATE_TMO = TMO_OFF;
        IQ_MIN = 4'h0;
        RQ_MIN = 4'h1;
        INSTR_TMO = TMO_OFF;
        RES_TMO = TMO_OFF;
        spur = 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        SRST = 1'b0;
        t_idle();
        t_single();
        t_burst();
        t_fault();
        `CHK(n_itmo + n_rtmo + n_unexp, 3)
        summarize();
    end
endmodule : custom_instruction_issuer_tb
`default_nettype wire
